// *** hw/tmr_core.sv ***
// 16-bit timer with byte access through a shared holding register
module tmr_core
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer pins
    input wire logic external_count_pin,
    input wire logic capture_pin,
    input wire logic comparator_out,
    output logic wave_out_a,
    output logic wave_out_b,
    // status
    output logic [3:0] timer_irq_req,
    output logic at_bottom,
    output logic at_max,
    output logic at_top
);
    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] timer_control_a_q, timer_control_b_q;
    logic [15:0] counter_value_q;
    logic [15:0] compare_value_a_q, compare_value_b_q; // buffers software writes
    logic [15:0] cmp_act_a_q, cmp_act_b_q;             // values compared
    logic [15:0] capture_value_q;
    logic [7:0] hold_q;
    logic [3:0] timer_irq_flags_q, timer_irq_mask_q;
    logic [PRESCALE_W-1:0] prescale_q;
    logic wave_a_q, wave_b_q;
    logic bottom_q, max_q, top_q;
    logic [3:0] irq_q;

    logic [3:0] mode;
    logic [2:0] clk_sel;
    logic [1:0] out_a, out_b;
    logic pwm_mode, top_from_a, top_from_cap;
    logic [15:0] top_val;
    logic timer_tick, ext_pulse, cap_pulse, cap_src;
    logic at_top_now, match_a, match_b, wrap, ovf_evt;
    logic acc_start, acc_done, wr_done, rd_take;
    logic mapped;
    logic [7:0] rd_byte;

    // ************************************************************
    // mode decode
    // ************************************************************
    assign mode = {timer_control_b_q[CB_MODE_HI+1:CB_MODE_HI],
                   timer_control_a_q[CA_MODE_LO+1:CA_MODE_LO]};
    assign clk_sel = timer_control_b_q[CB_CLKSEL+2:CB_CLKSEL];
    assign out_a = timer_control_a_q[CA_OUTA+1:CA_OUTA];
    assign out_b = timer_control_a_q[CA_OUTB+1:CA_OUTB];
    assign cap_src = timer_control_b_q[CB_CAP_SRC];
    assign pwm_mode = (mode == MODE_PWM8) || (mode == MODE_PWM9) || (mode == MODE_PWM10)
                      || (mode == MODE_PWM_CAP) || (mode == MODE_PWM_A);
    assign top_from_a = (mode == MODE_CTC_A) || (mode == MODE_PWM_A);
    assign top_from_cap = (mode == MODE_CTC_CAP) || (mode == MODE_PWM_CAP);

    // top selection per mode
    always_comb begin
        if (mode == MODE_PWM8) begin
            top_val = TOP_8BIT;
        end else if (mode == MODE_PWM9) begin
            top_val = TOP_9BIT;
        end else if (mode == MODE_PWM10) begin
            top_val = TOP_10BIT;
        end else if (top_from_a) begin
            top_val = cmp_act_a_q;
        end else if (top_from_cap) begin
            top_val = capture_value_q;
        end else begin
            top_val = CNT_MAX;
        end
    end

    // ************************************************************
    // clock select and prescaler
    // ************************************************************
    // free running prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_q <= '0;
        end else begin
            prescale_q <= prescale_q + 1'b1;
        end
    end

    tmr_edge_det u_ext_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(external_count_pin),
        .filt_en(1'b0),
        .rise_sel(clk_sel[0]),
        .edge_pulse(ext_pulse)
    );

    // tick source chosen by clock select
    always_comb begin
        case (clk_sel)
            CLK_DIV1: timer_tick = 1'b1;
            CLK_DIV8: timer_tick = &prescale_q[2:0];
            CLK_DIV64: timer_tick = &prescale_q[5:0];
            CLK_DIV256: timer_tick = &prescale_q[7:0];
            CLK_DIV1024: timer_tick = &prescale_q[9:0];
            CLK_EXT_FALL, CLK_EXT_RISE: timer_tick = ext_pulse;
            default: timer_tick = 1'b0;
        endcase
    end

    // ************************************************************
    // compare and limit detection
    // ************************************************************
    assign at_top_now = (counter_value_q == top_val);
    assign match_a = (counter_value_q == cmp_act_a_q);
    assign match_b = (counter_value_q == cmp_act_b_q);
    assign wrap = timer_tick && at_top_now;
    // pwm modes flag overflow at top, others when passing max
    assign ovf_evt = timer_tick && (pwm_mode ? at_top_now : (counter_value_q == CNT_MAX));

    // registered limit indications
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bottom_q <= 1'b0;
            max_q <= 1'b0;
            top_q <= 1'b0;
        end else begin
            bottom_q <= (counter_value_q == CNT_BOTTOM);
            max_q <= (counter_value_q == CNT_MAX);
            top_q <= at_top_now;
        end
    end

    // ************************************************************
    // apb handshake: one wait cycle, write lands at completion
    // ************************************************************
    assign acc_start = psel && penable && !pready;
    assign acc_done = psel && penable && pready;
    assign wr_done = acc_done && pwrite;
    assign rd_take = acc_start && !pwrite; // low byte and holding copy taken in one cycle

    always_comb begin
        if (paddr == ADDR_CTRL_A || paddr == ADDR_CTRL_B || paddr == ADDR_CNT_LO
            || paddr == ADDR_CNT_HI || paddr == ADDR_CMPA_LO || paddr == ADDR_CMPA_HI
            || paddr == ADDR_CMPB_LO || paddr == ADDR_CMPB_HI || paddr == ADDR_CAP_LO
            || paddr == ADDR_CAP_HI || paddr == ADDR_FLAGS || paddr == ADDR_MASK) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // read data mux
    always_comb begin
        if (paddr == ADDR_CTRL_A) begin
            rd_byte = timer_control_a_q;
        end else if (paddr == ADDR_CTRL_B) begin
            rd_byte = timer_control_b_q;
        end else if (paddr == ADDR_CNT_LO) begin
            rd_byte = counter_value_q[7:0];
        end else if (paddr == ADDR_CNT_HI || paddr == ADDR_CAP_HI) begin
            rd_byte = hold_q;
        end else if (paddr == ADDR_CMPA_LO) begin
            rd_byte = compare_value_a_q[7:0];
        end else if (paddr == ADDR_CMPA_HI) begin
            rd_byte = compare_value_a_q[15:8];
        end else if (paddr == ADDR_CMPB_LO) begin
            rd_byte = compare_value_b_q[7:0];
        end else if (paddr == ADDR_CMPB_HI) begin
            rd_byte = compare_value_b_q[15:8];
        end else if (paddr == ADDR_CAP_LO) begin
            rd_byte = capture_value_q[7:0];
        end else if (paddr == ADDR_FLAGS) begin
            rd_byte = {4'h0, timer_irq_flags_q};
        end else if (paddr == ADDR_MASK) begin
            rd_byte = {4'h0, timer_irq_mask_q};
        end else begin
            rd_byte = 8'h00;
        end
    end

    // ready, read data and error answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= acc_start;
            if (acc_start) begin
                prdata <= {24'h00_0000, rd_byte};
                pslverr <= !mapped;
            end else if (acc_done) begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // ************************************************************
    // holding register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 8'h00;
        end else if (wr_done && (paddr == ADDR_CNT_HI || paddr == ADDR_CMPA_HI
                     || paddr == ADDR_CMPB_HI || paddr == ADDR_CAP_HI)) begin
            hold_q <= pwdata[7:0];
        end else if (rd_take && paddr == ADDR_CNT_LO) begin
            hold_q <= counter_value_q[15:8];
        end else if (rd_take && paddr == ADDR_CAP_LO) begin
            hold_q <= capture_value_q[15:8];
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_a_q <= CTRL_RST;
            timer_control_b_q <= CTRL_RST;
            timer_irq_mask_q <= FLAGS_RST;
        end else if (wr_done) begin
            if (paddr == ADDR_CTRL_A) begin
                timer_control_a_q <= pwdata[7:0];
            end else if (paddr == ADDR_CTRL_B) begin
                timer_control_b_q <= pwdata[7:0];
            end else if (paddr == ADDR_MASK) begin
                timer_irq_mask_q <= pwdata[3:0];
            end
        end
    end

    // ************************************************************
    // counter
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value_q <= WORD_RST;
        end else if (wr_done && paddr == ADDR_CNT_LO) begin
            counter_value_q <= {hold_q, pwdata[7:0]};
        end else if (wrap) begin
            counter_value_q <= CNT_BOTTOM;
        end else if (timer_tick) begin
            counter_value_q <= counter_value_q + 16'h0001;
        end
    end

    // ************************************************************
    // compare buffers: software side and active side
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_a_q <= WORD_RST;
            compare_value_b_q <= WORD_RST;
        end else if (wr_done && paddr == ADDR_CMPA_LO) begin
            compare_value_a_q <= {hold_q, pwdata[7:0]};
        end else if (wr_done && paddr == ADDR_CMPB_LO) begin
            compare_value_b_q <= {hold_q, pwdata[7:0]};
        end
    end

    // pwm modes take new values only at top, others at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_act_a_q <= WORD_RST;
            cmp_act_b_q <= WORD_RST;
        end else if (!pwm_mode || wrap) begin
            cmp_act_a_q <= compare_value_a_q;
            cmp_act_b_q <= compare_value_b_q;
        end
    end

    // ************************************************************
    // input capture
    // ************************************************************
    tmr_edge_det u_cap_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(cap_src ? comparator_out : capture_pin),
        .filt_en(timer_control_b_q[CB_FILT_EN]),
        .rise_sel(timer_control_b_q[CB_CAP_EDGE]),
        .edge_pulse(cap_pulse)
    );

    // capture unless capture sets top, software load in every mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value_q <= WORD_RST;
        end else if (wr_done && paddr == ADDR_CAP_LO) begin
            capture_value_q <= {hold_q, pwdata[7:0]};
        end else if (cap_pulse && !top_from_cap) begin
            capture_value_q <= counter_value_q;
        end
    end

    // ************************************************************
    // interrupt flags: write one clears, a new event wins
    // ************************************************************
    logic [3:0] evt;
    logic [3:0] clr;
    assign evt = {cap_pulse && !top_from_cap,
                  timer_tick && match_a,
                  timer_tick && match_b,
                  ovf_evt};
    assign clr = (wr_done && paddr == ADDR_FLAGS) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq_flags_q <= FLAGS_RST;
        end else begin
            timer_irq_flags_q <= (timer_irq_flags_q & ~clr) | evt;
        end
    end

    // masked requests per source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 4'h0;
        end else begin
            irq_q <= timer_irq_flags_q & timer_irq_mask_q;
        end
    end

    // ************************************************************
    // waveform outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_a_q <= 1'b0;
        end else if (out_a == OUT_OFF || (pwm_mode && top_from_a)) begin
            wave_a_q <= 1'b0;
        end else if (pwm_mode) begin
            if (timer_tick && match_a) begin
                wave_a_q <= (out_a == OUT_SET);
            end else if (wrap) begin
                wave_a_q <= (out_a != OUT_SET);
            end
        end else if (timer_tick && match_a) begin
            wave_a_q <= (out_a == OUT_TOGGLE) ? ~wave_a_q : (out_a == OUT_SET);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_b_q <= 1'b0;
        end else if (out_b == OUT_OFF) begin
            wave_b_q <= 1'b0;
        end else if (pwm_mode) begin
            if (timer_tick && match_b) begin
                wave_b_q <= (out_b == OUT_SET);
            end else if (wrap) begin
                wave_b_q <= (out_b != OUT_SET);
            end
        end else if (timer_tick && match_b) begin
            wave_b_q <= (out_b == OUT_TOGGLE) ? ~wave_b_q : (out_b == OUT_SET);
        end
    end

    assign wave_out_a = wave_a_q;
    assign wave_out_b = wave_b_q;
    assign timer_irq_req = irq_q;
    assign at_bottom = bottom_q;
    assign at_max = max_q;
    assign at_top = top_q;
endmodule : tmr_core

// *** hw/tmr_pkg.sv ***
package tmr_pkg;
    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI = 8'h0c;
    localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
    localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
    localparam logic [7:0] ADDR_CMPB_LO = 8'h18;
    localparam logic [7:0] ADDR_CMPB_HI = 8'h1c;
    localparam logic [7:0] ADDR_CAP_LO = 8'h20;
    localparam logic [7:0] ADDR_CAP_HI = 8'h24;
    localparam logic [7:0] ADDR_FLAGS = 8'h28;
    localparam logic [7:0] ADDR_MASK = 8'h2c;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int CA_MODE_LO = 0;   // control a [1:0]: low mode bits
    localparam int CA_OUTB = 4;      // control a [5:4]: output mode b
    localparam int CA_OUTA = 6;      // control a [7:6]: output mode a
    localparam int CB_CLKSEL = 0;    // control b [2:0]: clock select
    localparam int CB_MODE_HI = 3;   // control b [4:3]: high mode bits
    localparam int CB_CAP_SRC = 5;   // control b [5]: 1 = comparator
    localparam int CB_CAP_EDGE = 6;  // control b [6]: 1 = rising
    localparam int CB_FILT_EN = 7;   // control b [7]: noise filter on
    localparam int FL_OVF = 0;
    localparam int FL_MATCH_B = 1;
    localparam int FL_MATCH_A = 2;
    localparam int FL_CAP = 3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    // ************************************************************
    // counter limits and modes
    // ************************************************************
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_PWM8 = 4'h1;
    localparam logic [3:0] MODE_PWM9 = 4'h2;
    localparam logic [3:0] MODE_PWM10 = 4'h3;
    localparam logic [3:0] MODE_CTC_A = 4'h4;
    localparam logic [3:0] MODE_CTC_CAP = 4'hc;
    localparam logic [3:0] MODE_PWM_CAP = 4'he;
    localparam logic [3:0] MODE_PWM_A = 4'hf;
    localparam logic [2:0] CLK_STOP = 3'h0;
    localparam logic [2:0] CLK_DIV1 = 3'h1;
    localparam logic [2:0] CLK_DIV8 = 3'h2;
    localparam logic [2:0] CLK_DIV64 = 3'h3;
    localparam logic [2:0] CLK_DIV256 = 3'h4;
    localparam logic [2:0] CLK_DIV1024 = 3'h5;
    localparam logic [2:0] CLK_EXT_FALL = 3'h6;
    localparam logic [2:0] CLK_EXT_RISE = 3'h7;
    localparam logic [1:0] OUT_OFF = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_CLEAR = 2'h2;
    localparam logic [1:0] OUT_SET = 2'h3;
    localparam int PRESCALE_W = 10;
    localparam int FILT_SAMPLES = 4;
    localparam logic [31:0] ACCESS_WAIT = 32'd1; // wait cycles per apb access
endpackage : tmr_pkg

// *** hw/tmr_edge_det.sv ***
// synchroniser, optional noise filter and edge pulse for one pin
module tmr_edge_det
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin and settings
    input wire logic pin,
    input wire logic filt_en,
    input wire logic rise_sel,
    // event
    output logic edge_pulse
);
    // ************************************************************
    // synchroniser and filter
    // ************************************************************
    logic sync1_q, sync2_q, level_q, prev_q;
    logic [FILT_SAMPLES-1:0] hist_q;
    logic stable;

    // two flops before any logic looks at the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
        end
    end

    // sample history for the noise filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_q <= '0;
        end else begin
            hist_q <= {hist_q[FILT_SAMPLES-2:0], sync2_q};
        end
    end

    assign stable = (&hist_q) | (~|hist_q);

    // level follows only after all samples agree when filtering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 1'b0;
            prev_q <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            if (!filt_en) begin
                level_q <= sync2_q;
            end else if (stable) begin
                level_q <= hist_q[0];
            end
            prev_q <= level_q;
            edge_pulse <= rise_sel ? (level_q & ~prev_q) : (~level_q & prev_q);
        end
    end
endmodule : tmr_edge_det

// *** verif/tmr_core_properties.sv ***
// ****
// bus and status checks on the core ports
// ****
module tmr_core_properties
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // status
    input wire logic at_bottom,
    input wire logic at_max
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // first access cycle, then the answer
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_done; psel && penable && pready; endsequence
    a_one_wait: assert property (s_wait |=> s_done) else $error("no answer after wait");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_inside: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_byte_only: assert property (pready |-> prdata[31:8] == 24'h0) else $error("wide data");
    a_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("data not idle");
    a_unmapped_err: assert property (psel && penable && pready && paddr > ADDR_MASK |-> pslverr)
        else $error("unmapped not refused");
    a_mapped_ok: assert property (pready && paddr <= ADDR_MASK && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped refused");
    a_limits_apart: assert property (at_bottom |-> !at_max) else $error("bottom and max");
endmodule : tmr_core_properties

// *** verif/tmr_pins_model.sv ***
// timer pin side: count clock and capture sources, idle low
module tmr_pins_model (
    // clock
    input wire logic pclk,
    // timer pins
    output logic external_count_pin,
    output logic capture_pin,
    output logic comparator_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins rest low
    initial begin
        external_count_pin = 1'b0;
        capture_pin = 1'b0;
        comparator_out = 1'b0;
    end
    // n full periods, halves of three cycles so sampling never misses one
    task automatic count_edges(input int n);
        repeat (2 * n) begin
            repeat (3) @(posedge pclk);
            external_count_pin <= !external_count_pin;
        end
    endtask : count_edges
    // high pulse of len cycles on the chosen capture source
    task automatic cap_pulse(input bit src, input int len);
        comparator_out <= src;
        capture_pin <= !src;
        repeat (len) @(posedge pclk);
        comparator_out <= 1'b0;
        capture_pin <= 1'b0;
        repeat (12) @(posedge pclk);
    endtask : cap_pulse
endmodule : tmr_pins_model

// *** verif/timer16_core_and_byte_access_tb.sv ***
module timer16_core_and_byte_access_tb;
    import tmr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, x_pin, c_pin, k_pin;
    logic at_bottom, at_max, at_top, wa, wb;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] irq;
    logic [32:0] exp_q[$];
    logic [15:0] v, w;
    int bad_count = 0;
    int n_checks = 0;
    tmr_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin(x_pin), .capture_pin(c_pin),
        .comparator_out(k_pin), .wave_out_a(wa), .wave_out_b(wb), .timer_irq_req(irq),
        .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));
    tmr_pins_model model_u (.pclk(pclk), .external_count_pin(x_pin), .capture_pin(c_pin),
        .comparator_out(k_pin));
    // clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    // one apb transfer; reads leave their expected {err, data} in the queue
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
        input logic [32:0] e);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (!wr)
            exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && !(k > 0 && pready); k++)
            @(posedge pclk);
        if (!pready) begin
            bad_count++;
            close_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h0, {25'h0, e});
    endtask : rd
    task automatic w16(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a + 8'h4, d[15:8], 33'h0);
        apb(1'b1, a, d[7:0], 33'h0);
    endtask : w16
    task automatic r16(input logic [7:0] a, input logic [15:0] e);
        rd(a, e[7:0]);
        rd(a + 8'h4, e[15:8]);
    endtask : r16
    // read results checked against the oldest note
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, exp_q.pop_front());
    // ****
    // scenarios
    // ****
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        v = 16'($urandom(32'hea99));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 48; a += 4)
            rd(8'(a), 8'h0);
        apb(1'b0, 8'h30, 8'h0, {1'b1, 32'h0});
        w = 16'($urandom);
        apb(1'b1, ADDR_CTRL_A, w[7:0], 33'h0);
        rd(ADDR_CTRL_A, w[7:0]);
        apb(1'b1, ADDR_CTRL_A, 8'h0, 33'h0);
        $display("reset and control test done");
        apb(1'b1, ADDR_CNT_HI, v[15:8], 33'h0);
        r16(ADDR_CNT_LO, 16'h0);
        w16(ADDR_CNT_LO, v);
        repeat (20) @(posedge pclk);
        r16(ADDR_CNT_LO, v);
        for (int i = 0; i < 2; i++) begin
            w = 16'($urandom);
            w16(ADDR_CMPA_LO + 8'(8 * i), w);
            rd(ADDR_CNT_LO, v[7:0]);
            rd(ADDR_CMPA_LO + 8'(8 * i), w[7:0]);
            rd(ADDR_CMPA_HI + 8'(8 * i), w[15:8]);
            rd(ADDR_CNT_HI, v[15:8]);
        end
        w16(ADDR_CNT_LO, CNT_MAX);
        @(posedge pclk);
        chk({32'h0, at_max}, 33'h1);
        chk({32'h0, at_top}, 33'h1);
        w16(ADDR_CNT_LO, CNT_BOTTOM);
        @(posedge pclk);
        chk({32'h0, at_bottom}, 33'h1);
        $display("byte access test done");
        apb(1'b1, ADDR_MASK, 8'h0f, 33'h0);
        apb(1'b1, ADDR_CTRL_A, {OUT_SET, OUT_SET, 4'h0}, 33'h0);
        w16(ADDR_CMPA_LO, 16'hfff8);
        w16(ADDR_CMPB_LO, 16'hfffa);
        w16(ADDR_CNT_LO, 16'hfff0);
        apb(1'b1, ADDR_CTRL_B, {5'h0, CLK_DIV1}, 33'h0);
        repeat (40) @(posedge pclk);
        apb(1'b1, ADDR_CTRL_B, 8'h0, 33'h0);
        rd(ADDR_FLAGS, 8'h07);
        chk({29'h0, irq}, 33'h7);
        chk({31'h0, wa, wb}, 33'h3);
        apb(1'b1, ADDR_MASK, 8'h01, 33'h0);
        @(posedge pclk);
        chk({29'h0, irq}, 33'h1);
        apb(1'b1, ADDR_FLAGS, 8'h07, 33'h0);
        rd(ADDR_FLAGS, 8'h0);
        $display("flag test done");
        for (int s = 6; s < 8; s++) begin
            w16(ADDR_CNT_LO, 16'h0);
            apb(1'b1, ADDR_CTRL_B, 8'(s), 33'h0);
            model_u.count_edges(5);
            repeat (6) @(posedge pclk);
            apb(1'b1, ADDR_CTRL_B, 8'h0, 33'h0);
            r16(ADDR_CNT_LO, 16'h5);
        end
        $display("external count test done");
        for (int s = 0; s < 2; s++) begin
            w16(ADDR_CNT_LO, v + 16'(s));
            apb(1'b1, ADDR_CTRL_B, 8'hc0 | 8'(s << 5), 33'h0);
            model_u.cap_pulse(s[0], 1);
            rd(ADDR_FLAGS, 8'h0);
            model_u.cap_pulse(s[0], 10);
            rd(ADDR_FLAGS, 8'h08);
            r16(ADDR_CAP_LO, v + 16'(s));
            apb(1'b1, ADDR_FLAGS, 8'h08, 33'h0);
        end
        $display("capture test done");
        close_out();
    end
endmodule : timer16_core_and_byte_access_tb
bind tmr_core tmr_core_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .at_bottom(at_bottom), .at_max(at_max));
